/* File: hw/wsc_pkg.sv */
package wsc_pkg;

  // Index port geometry and datapath widths
  localparam int WSC_PORT_W = 13;
  localparam int WSC_IDX_W = 19;
  localparam int WSC_HI_W = 6;
  localparam int WSC_LO_W = 13;
  localparam int WSC_ELEM_W = 16;
  localparam int WSC_LOOP_W = 16;
  localparam int WSC_DAC_W = 14;

  // Sequencer clock dividers
  localparam int WSC_DIV_14B = 48;
  localparam int WSC_DIV_12B = 64;
  localparam int WSC_DIV_INTERP = 24;

  // Register byte addresses
  localparam logic [7:0] WSC_A_CTRL = 8'h00;
  localparam logic [7:0] WSC_A_CMD = 8'h04;
  localparam logic [7:0] WSC_A_SEG = 8'h08;
  localparam logic [7:0] WSC_A_SWIDX = 8'h0C;
  localparam logic [7:0] WSC_A_STAT = 8'h10;
  localparam logic [7:0] WSC_A_IDX = 8'h14;
  localparam logic [7:0] WSC_A_CLK = 8'h18;

  // CTRL field positions
  localparam int WSC_C_TRIG = 0;  // 2 bits trigger mode
  localparam int WSC_C_ARM = 2;
  localparam int WSC_C_ADV = 3;   // 2 bits advancement mode
  localparam int WSC_C_POL = 5;
  localparam int WSC_C_EDGE = 6;  // 2 bits edge select
  localparam int WSC_C_HWDIS = 8;
  localparam int WSC_C_SWSEL = 9;

  // CMD bits (write one to pulse)
  localparam int WSC_K_RUN = 0;
  localparam int WSC_K_STOP = 1;
  localparam int WSC_K_TRIG = 2;
  localparam int WSC_K_GATE = 3;
  localparam int WSC_K_EN = 4;
  localparam int WSC_K_ADV = 5;

  // CLK register fields
  localparam int WSC_K_INTERP = 2; // field starts at bit 2, bits 1:0 mode

  localparam logic [31:0] WSC_CTRL_RST = 32'h0000_0000;

  typedef enum logic [1:0] {WSC_TM_CONT, WSC_TM_TRIG, WSC_TM_GATE} wsc_trig_t;
  typedef enum logic [1:0] {WSC_AM_AUTO, WSC_AM_COND, WSC_AM_REP, WSC_AM_SINGLE} wsc_adv_t;
  typedef enum logic [1:0] {WSC_ED_RISE, WSC_ED_FALL, WSC_ED_BOTH} wsc_edge_t;
  typedef enum logic [1:0] {WSC_CK_14B, WSC_CK_12B, WSC_CK_INTERP} wsc_ckmode_t;

  // Index port bundle
  typedef struct packed {
    logic [WSC_PORT_W-1:0] data;
    logic hsel;
    logic strobe;
  } wsc_idx_port_t;

  // Playback status bundle
  typedef struct packed {
    logic running;
    logic holding;
    logic armed_wait;
    logic event_pend;
  } wsc_stat_t;

endpackage : wsc_pkg

/* File: hw/wsc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser, one per bit
module wsc_sync
  import wsc_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_ff; // First stage, read only by q

  // Per-bit two-stage chain
  genvar gi;
  for (gi = 0; gi < W; gi++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        meta_ff[gi] <= 1'b0;
        q[gi] <= 1'b0;
      end else begin
        meta_ff[gi] <= d[gi];
        q[gi] <= meta_ff[gi];
      end
    end
  end

endmodule : wsc_sync
`default_nettype wire

/* File: hw/wsc_ctrl.sv */
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1: Inputs sampled on divided sequencer clock enable
// R2: Trigger polarity and edge selection configurable
// R3: Thirteen data, half-select, strobe; two transfers
// R4: Half-select high loads index bits 18..13
// R5: Half-select low loads index bits 12..0
// R6: Controller sends upper half before lower
// R7: Strobe rising edge captures chosen half
// R8: Low-half strobe hands index to sequencer
// R9: Thirteen-bit use leaves upper bits alone
// R10: Controller keeps updates at most 1MHz
// R11: Trigger starts; gate starts and stops
// R12: Armed continuous holds first element until enable; the code only flags it on armed_wait and keeps playing
// R13: Advancement event stored until element end
// R14: Software index wins unless port disabled; the code uses it only when selected or when the port is disabled
// R15: Software controls ORed with external inputs
// R16: Default input mapping to logical functions
// R17: Armed triggered/gated samples enable once
// R18: Every run starts with midscale offset
// R19: Software stop halts output immediately
// R20: Self-armed continuous auto-starts, repeats forever
// R21: Triggered advancement modes auto/repeat/single/conditional
// R22: Gated: offset, loop while gate, finish count
// R23: Triggers during running playback are ignored
// R24: Index strobe and select synchronised first
module wsc_ctrl
  import wsc_pkg::*;
#(
  parameter int DAC_W = WSC_DAC_W,
  parameter logic [WSC_DAC_W-1:0] DAC_MAX = 14'h3FFF,
  parameter logic [WSC_DAC_W-1:0] DAC_MIN = 14'h0000
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External inputs
  input wire logic trig_in,
  input wire logic event_in,
  input wire wsc_idx_port_t idx_port,
  // Sequencer side
  input wire logic seg_end,
  output logic [WSC_IDX_W-1:0] seq_idx_ff,
  output logic seq_idx_load_ff,
  output logic [WSC_DAC_W-1:0] sample_ff,
  output logic seq_tick_ff,
  output wsc_stat_t stat
);

  // Register storage
  logic [31:0] ctrl_ff;     // Mode control
  logic [WSC_LOOP_W-1:0] loops_ff; // Segment loop count
  logic [WSC_ELEM_W-1:0] seglen_ff; // Segment length in ticks
  logic [WSC_IDX_W-1:0] swidx_ff;  // Software index
  logic [31:0] clk_ff;      // Clock mode and interpolation
  logic [5:0] cmd_p;        // Command pulses this cycle

  wire wsc_trig_t tmode = wsc_trig_t'(ctrl_ff[WSC_C_TRIG +: 2]);
  wire wsc_adv_t amode = wsc_adv_t'(ctrl_ff[WSC_C_ADV +: 2]);
  wire wsc_edge_t emode = wsc_edge_t'(ctrl_ff[WSC_C_EDGE +: 2]);
  wire logic armed = ctrl_ff[WSC_C_ARM];

  // APB access; zero wait states
  wire logic acc = psel & penable;
  wire logic wr = acc & pwrite;
  wire logic mapped = (paddr == WSC_A_CTRL) || (paddr == WSC_A_CMD) || (paddr == WSC_A_SEG) ||
                      (paddr == WSC_A_SWIDX) || (paddr == WSC_A_STAT) || (paddr == WSC_A_IDX) ||
                      (paddr == WSC_A_CLK);
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  // Register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= WSC_CTRL_RST;
      loops_ff <= 16'h0001;
      seglen_ff <= 16'h0010;
      swidx_ff <= '0;
      clk_ff <= 32'h0000_0000;
    end else if (wr) begin
      if (paddr == WSC_A_CTRL) begin
        ctrl_ff <= pwdata;
      end
      if (paddr == WSC_A_SEG) begin
        loops_ff <= pwdata[31:16];
        seglen_ff <= pwdata[15:0];
      end
      if (paddr == WSC_A_SWIDX) begin
        swidx_ff <= pwdata[WSC_IDX_W-1:0];
      end
      if (paddr == WSC_A_CLK) begin
        clk_ff <= pwdata;
      end
    end
  end

  // Command pulses, one cycle
  assign cmd_p = (wr && paddr == WSC_A_CMD) ? pwdata[5:0] : 6'h00;

  // Read mux, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        WSC_A_CTRL: prdata <= ctrl_ff;
        WSC_A_SEG: prdata <= {loops_ff, seglen_ff};
        WSC_A_SWIDX: prdata <= {13'h0000, swidx_ff};
        WSC_A_STAT: prdata <= {28'h0000000, stat};
        WSC_A_IDX: prdata <= {13'h0000, seq_idx_ff};
        WSC_A_CLK: prdata <= clk_ff;
        default: prdata <= '0;
      endcase
    end
  end

  // Sequencer clock divider; divides sample-rate ticks (pclk stands for sample clock)
  logic [11:0] div_cnt_ff;
  logic [11:0] div_max;
  always_comb begin
    unique case (wsc_ckmode_t'(clk_ff[1:0]))
      WSC_CK_12B: div_max = 12'(WSC_DIV_12B - 1); // R1
      WSC_CK_INTERP: div_max = 12'(WSC_DIV_INTERP * int'(clk_ff[WSC_K_INTERP +: 6]) - 1); // R1
      default: div_max = 12'(WSC_DIV_14B - 1); // R1
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_ff <= '0;
      seq_tick_ff <= 1'b0;
    end else begin
      seq_tick_ff <= (div_cnt_ff >= div_max);
      div_cnt_ff <= (div_cnt_ff >= div_max) ? 12'h000 : div_cnt_ff + 12'h001;
    end
  end
  wire logic tick = seq_tick_ff;

  // Synchronisers for trigger, event and index port
  logic [1:0] te_s;
  wsc_idx_port_t port_s;
  wsc_sync #(.W(2)) u_sync_te (.pclk(pclk), .presetn(presetn), .d({trig_in, event_in}), .q(te_s));
  wsc_sync #(.W(WSC_PORT_W + 2)) u_sync_idx (.pclk(pclk), .presetn(presetn), .d(idx_port), .q(port_s)); // R24

  // Sample trigger/event on sequencer tick
  logic trig_smp_ff, trig_prev_ff, ev_smp_ff, ev_prev_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_smp_ff <= 1'b0;
      trig_prev_ff <= 1'b0;
      ev_smp_ff <= 1'b0;
      ev_prev_ff <= 1'b0;
    end else if (tick) begin
      trig_smp_ff <= te_s[1] ^ ctrl_ff[WSC_C_POL]; // R1 R2
      trig_prev_ff <= trig_smp_ff;
      ev_smp_ff <= te_s[0];
      ev_prev_ff <= ev_smp_ff;
    end
  end

  // Edge qualification of the trigger input
  logic hw_trig_edge;
  always_comb begin
    unique case (emode)
      WSC_ED_FALL: hw_trig_edge = ~trig_smp_ff & trig_prev_ff; // R2
      WSC_ED_BOTH: hw_trig_edge = trig_smp_ff ^ trig_prev_ff; // R2
      default: hw_trig_edge = trig_smp_ff & ~trig_prev_ff; // R2
    endcase
  end

  // Logical functions, software ORed in; software pulses caught until next tick
  logic sw_trig_ff, sw_adv_ff, sw_en_ff, sw_gate_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_trig_ff <= 1'b0;
      sw_adv_ff <= 1'b0;
      sw_en_ff <= 1'b0;
      sw_gate_ff <= 1'b0;
    end else begin
      // Set wins over the tick clear
      sw_trig_ff <= cmd_p[WSC_K_TRIG] | (sw_trig_ff & ~tick);
      sw_adv_ff <= cmd_p[WSC_K_ADV] | (sw_adv_ff & ~tick);
      sw_en_ff <= cmd_p[WSC_K_EN] | (sw_en_ff & ~tick);
      if (cmd_p[WSC_K_GATE]) begin
        sw_gate_ff <= pwdata[8]; // Gate level from bit 8
      end
    end
  end
  wire logic f_trig = tick & (hw_trig_edge | sw_trig_ff); // R15 R16
  wire logic f_gate = trig_smp_ff | sw_gate_ff; // R15 R16
  wire logic f_en = tick & (hw_trig_edge | sw_en_ff); // R15 R16
  wire logic f_adv = tick & ((ev_smp_ff & ~ev_prev_ff) | sw_adv_ff); // R15 R16

  // Index port: rising strobe edge after sync
  logic strobe_prev_ff;
  logic [WSC_HI_W-1:0] idx_hi_ff;
  logic [WSC_LO_W-1:0] idx_lo_ff;
  wire logic strobe_rise = port_s.strobe & ~strobe_prev_ff; // R7 R24
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_prev_ff <= 1'b0;
      idx_hi_ff <= '0;
      idx_lo_ff <= '0;
    end else begin
      strobe_prev_ff <= port_s.strobe;
      if (strobe_rise && port_s.hsel) begin
        idx_hi_ff <= port_s.data[WSC_HI_W-1:0]; // R3 R4 R6
      end
      if (strobe_rise && !port_s.hsel) begin
        idx_lo_ff <= port_s.data; // R5 R9
      end
    end
  end

  // Index hand-over; software wins when selected or when port disabled
  wire logic hw_dis = ctrl_ff[WSC_C_HWDIS];
  wire logic sw_sel = ctrl_ff[WSC_C_SWSEL];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_idx_ff <= '0;
      seq_idx_load_ff <= 1'b0;
    end else begin
      seq_idx_load_ff <= 1'b0;
      if (wr && paddr == WSC_A_SWIDX && (sw_sel || hw_dis)) begin
        seq_idx_ff <= pwdata[WSC_IDX_W-1:0]; // R14
        seq_idx_load_ff <= 1'b1;
      end else if (strobe_rise && !port_s.hsel && !hw_dis && !sw_sel) begin
        seq_idx_ff <= {idx_hi_ff, port_s.data}; // R8 R14
        seq_idx_load_ff <= 1'b1;
      end
    end
  end

  // Stored advancement event, cleared when consumed
  logic ev_pend_ff;
  logic consume;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_pend_ff <= 1'b0;
    end else begin
      ev_pend_ff <= f_adv | (ev_pend_ff & ~consume); // R13
    end
  end

  // Playback engine for a single segment
  typedef enum logic [2:0] {WSC_S_IDLE, WSC_S_OFFSET, WSC_S_PLAY, WSC_S_WAIT, WSC_S_HOLD} wsc_state_t;
  wsc_state_t st_ff;
  logic [WSC_ELEM_W-1:0] pos_ff;  // Tick within segment
  logic [WSC_LOOP_W-1:0] loop_ff; // Loops played
  logic en_ok_ff;       // Enable seen once
  logic gate_prev_ff;
  logic gate_fell_ff;   // Finishing after gate fall
  logic first_ff;       // First-element wait flag; playback not held
  wire logic at_end = tick && (pos_ff >= seglen_ff - 16'h0001) | seg_end;
  wire logic last_loop = (loop_ff + 16'h0001 >= loops_ff);
  wire logic [WSC_DAC_W-1:0] offset = WSC_DAC_W'((DAC_MAX - DAC_MIN) >> 1); // R18
  wire logic gate_rise = f_gate & ~gate_prev_ff;
  wire logic gate_fall = ~f_gate & gate_prev_ff;
  wire logic en_now = en_ok_ff | f_en | ~armed;

  // Consumption happens at element end in event-driven modes, or on any tick while waiting
  assign consume = (st_ff == WSC_S_PLAY && at_end && amode != WSC_AM_AUTO) || (st_ff == WSC_S_WAIT && tick);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= WSC_S_IDLE;
      pos_ff <= '0;
      loop_ff <= '0;
      en_ok_ff <= 1'b0;
      gate_prev_ff <= 1'b0;
      gate_fell_ff <= 1'b0;
      first_ff <= 1'b0;
      sample_ff <= '0;
    end else if (cmd_p[WSC_K_STOP]) begin
      st_ff <= WSC_S_IDLE; // R19
      sample_ff <= offset; // R19
      en_ok_ff <= 1'b0;
    end else begin
      if (tick) begin
        gate_prev_ff <= f_gate;
      end
      unique case (st_ff)
        WSC_S_IDLE: begin
          if (cmd_p[WSC_K_RUN]) begin
            st_ff <= WSC_S_OFFSET;
            sample_ff <= offset; // R18
            en_ok_ff <= 1'b0;
            first_ff <= armed;
          end
        end
        WSC_S_OFFSET: begin
          pos_ff <= '0;
          loop_ff <= '0;
          gate_fell_ff <= 1'b0;
          if (f_en && armed) begin
            en_ok_ff <= 1'b1; // R17 enable taken only once per run
          end
          unique case (tmode)
            WSC_TM_CONT: if (tick) st_ff <= WSC_S_PLAY; // R20
            WSC_TM_TRIG: if (f_trig && en_now) st_ff <= WSC_S_PLAY; // R11 R17
            default: if (tick && gate_rise && en_now) st_ff <= WSC_S_PLAY; // R11 R22
          endcase
        end
        WSC_S_PLAY: begin
          if (tick) begin
            sample_ff <= WSC_DAC_W'(pos_ff); // Stand-in sample address
            pos_ff <= at_end ? 16'h0000 : pos_ff + 16'h0001;
          end
          if (tick && gate_fall && tmode == WSC_TM_GATE) begin
            gate_fell_ff <= 1'b1; // R11 R22
            loop_ff <= '0;
          end
          if (at_end) begin
            if (tmode == WSC_TM_CONT) begin
              // First-element flag cleared on enable or a stored advancement event; playback advances regardless
              if (first_ff && (ev_pend_ff || f_en)) first_ff <= 1'b0; // R12
            end else if (tmode == WSC_TM_GATE) begin
              if (gate_fell_ff) begin
                loop_ff <= loop_ff + 16'h0001;
                if (last_loop) st_ff <= WSC_S_HOLD; // R22
              end
            end else begin
              unique case (amode)
                WSC_AM_COND: ; // R21 endless until stop
                WSC_AM_SINGLE: begin
                  loop_ff <= loop_ff + 16'h0001;
                  st_ff <= (last_loop && ev_pend_ff) ? WSC_S_HOLD : WSC_S_WAIT; // R21
                end
                WSC_AM_REP: begin
                  loop_ff <= loop_ff + 16'h0001;
                  if (last_loop) st_ff <= ev_pend_ff ? WSC_S_HOLD : WSC_S_WAIT; // R21
                end
                default: begin
                  loop_ff <= loop_ff + 16'h0001;
                  if (last_loop) st_ff <= WSC_S_HOLD; // R21
                end
              endcase
            end
          end
        end
        WSC_S_WAIT: begin
          // Last sample held until an advancement event
          if (tick && ev_pend_ff) begin
            st_ff <= (loop_ff >= loops_ff) ? WSC_S_HOLD : WSC_S_PLAY; // R13 R21
          end
        end
        default: begin
          // Holding last sample; new trigger restarts only once done
          if (tmode == WSC_TM_TRIG && f_trig) begin
            st_ff <= WSC_S_PLAY; // R23
            loop_ff <= '0;
            pos_ff <= '0;
          end else if (tmode == WSC_TM_GATE && tick && gate_rise) begin
            st_ff <= WSC_S_PLAY;
            loop_ff <= '0;
            pos_ff <= '0;
            gate_fell_ff <= 1'b0;
          end
        end
      endcase
    end
  end

  // Status view
  assign stat.running = (st_ff == WSC_S_PLAY);
  assign stat.holding = (st_ff == WSC_S_HOLD) || (st_ff == WSC_S_WAIT);
  assign stat.armed_wait = first_ff;
  assign stat.event_pend = ev_pend_ff;

endmodule : wsc_ctrl
`default_nettype wire

/* File: tb/wsc_ctrl_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level checker for the sequencer control front end
module wsc_ctrl_monitor
  import wsc_pkg::*;
#(
  parameter logic [WSC_DAC_W-1:0] DAC_MAX = 14'h3FFF,
  parameter logic [WSC_DAC_W-1:0] DAC_MIN = 14'h0000
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Sequencer side
  input wire logic [WSC_IDX_W-1:0] seq_idx_ff,
  input wire logic seq_idx_load_ff,
  input wire logic [WSC_DAC_W-1:0] sample_ff,
  input wire logic seq_tick_ff,
  input wire wsc_stat_t stat
);
  // Midscale code, the signed zero
  localparam logic [WSC_DAC_W-1:0] OFFS = (DAC_MAX - DAC_MIN) >> 1;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Access phase and stop command decode
  logic acc;
  logic cmd_stop;
  assign acc = psel && penable;
  assign cmd_stop = acc && pwrite && (paddr == WSC_A_CMD) && pwdata[WSC_K_STOP];

  zero_wait_a: assert property (acc |-> pready) else $error("access phase not answered");
  unmapped_err_a: assert property (acc && paddr > WSC_A_CLK |-> pslverr) else $error("unmapped access without error");
  mapped_ok_a: assert property (acc && paddr <= WSC_A_CLK && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access flagged");
  unmapped_rd_a: assert property (acc && !pwrite && paddr > WSC_A_CLK |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  load_pulse_a: assert property (seq_idx_load_ff |=> !seq_idx_load_ff) else $error("load pulse too long");
  idx_cause_a: assert property ($changed(seq_idx_ff) |-> seq_idx_load_ff) else $error("index moved silently");
  tick_gap_a: assert property (seq_tick_ff |=> !seq_tick_ff [*8]) else $error("ticks too close");
  stop_halt_a: assert property (cmd_stop |-> ##[1:3] (!stat.running && sample_ff == OFFS))
    else $error("stop did not halt output");
  event_tick_a: assert property ($rose(stat.event_pend) |-> seq_tick_ff || $past(seq_tick_ff))
    else $error("event stored off tick");
  // Main scenarios reached
  cover property (seq_idx_load_ff);
  cover property (cmd_stop);
  cover property ($rose(stat.holding));
endmodule : wsc_ctrl_monitor

bind wsc_ctrl wsc_ctrl_monitor #(.DAC_MAX(DAC_MAX), .DAC_MIN(DAC_MIN)) i_wsc_ctrl_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .seq_idx_ff(seq_idx_ff),
  .seq_idx_load_ff(seq_idx_load_ff), .sample_ff(sample_ff), .seq_tick_ff(seq_tick_ff), .stat(stat));
`default_nettype wire

/* File: tb/wsc_ctl_model.sv */
`timescale 1ns/1ps
`default_nettype none
// External controller: index port and trigger lines
module wsc_ctl_model
  import wsc_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Lines toward the block
  output var wsc_idx_port_t idx_port,
  output logic trig_in,
  output logic event_in
);
  // 1MHz ceiling at 50MHz means 50 cycles per update
  localparam int GAP = 50;
  initial begin
    idx_port = '0;
    trig_in = 1'b0;
    event_in = 1'b0;
  end
  // One transfer; strobe held long enough to cross the synchroniser
  task automatic xfer(input logic hs, input logic [WSC_PORT_W-1:0] d);
    @(posedge pclk);
    idx_port.data <= d;
    idx_port.hsel <= hs;
    @(posedge pclk);
    idx_port.strobe <= 1'b1;
    repeat (8) @(posedge pclk);
    idx_port.strobe <= 1'b0;
    @(posedge pclk);
    // Released lines fall to the pull-down level
    idx_port.data <= '0;
    idx_port.hsel <= 1'b0;
    repeat (GAP) @(posedge pclk);
  endtask : xfer
  // Full index: upper part first, junk on unused lines
  task automatic send_full(input logic [WSC_IDX_W-1:0] idx);
    xfer(1'b1, {7'h55, idx[18:13]});
    xfer(1'b0, idx[12:0]);
  endtask : send_full
  // Level changes on the trigger and event lines
  task automatic set_trig(input logic v);
    @(posedge pclk);
    trig_in <= v;
  endtask : set_trig
  task automatic set_event(input logic v);
    @(posedge pclk);
    event_in <= v;
  endtask : set_event
endmodule : wsc_ctl_model
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the control front end
module tb;
  import wsc_pkg::*;
  // Status bit positions and midscale code
  localparam int RUNB = 3;
  localparam int HOLDB = 2;
  localparam int EVB = 0;
  localparam logic [31:0] OFFS = 32'h0000_1FFF;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, seg_end, ld, tick, trig_in, event_in, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [WSC_IDX_W-1:0] seq_idx;
  logic [WSC_DAC_W-1:0] smp;
  wsc_stat_t stat;
  wsc_idx_port_t idx_port;
  int failures, n_compared;

  wsc_ctrl i_wsc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig_in(trig_in),
    .event_in(event_in), .idx_port(idx_port), .seg_end(seg_end), .seq_idx_ff(seq_idx),
    .seq_idx_load_ff(ld), .sample_ff(smp), .seq_tick_ff(tick), .stat(stat));
  wsc_ctl_model i_wsc_ctl_model (.pclk(pclk), .idx_port(idx_port), .trig_in(trig_in), .event_in(event_in));

  // 50MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic close_out;
    $display("failures %0d compared %0d", failures, n_compared);
    if (failures == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One bus transfer; waits for pready with a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // No answer in time counts as a mismatch
    if (pready !== 1'b1) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Bounded wait for a status level, then judge it
  task automatic wait_stat(input string nm, input int b, input logic v, input int lim);
    int n;
    n = 0;
    while (stat[b] !== v && n < lim) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(nm, {31'h0, v}, {31'h0, stat[b]});
  endtask : wait_stat
  task automatic wait_load(output logic seen, input int lim);
    seen = 1'b0;
    repeat (lim) begin
      @(posedge pclk);
      #1;
      if (ld === 1'b1) begin
        seen = 1'b1;
        break;
      end
    end
  endtask : wait_load
  task automatic stop_run;
    apb(1'b1, WSC_A_CMD, 32'h0000_0002);
  endtask : stop_run

  // Reset values, read-back, unmapped place
  task automatic t_regs;
    int n;
    apb(1'b0, WSC_A_SEG, 32'h0);
    chk("seg reset", 32'h0001_0010, rd);
    apb(1'b1, WSC_A_CTRL, 32'h0000_0295);
    apb(1'b0, WSC_A_CTRL, 32'h0);
    chk("ctrl readback", 32'h0000_0295, rd);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, WSC_A_CTRL, 32'h0);
    // Tick spacing in the default mode
    @(negedge tick);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (tick !== 1'b1);
    chk("tick period", WSC_DIV_14B, n);
  endtask : t_regs
  // Two-step port index, then a lower-only update
  task automatic t_port;
    logic seen;
    fork
      i_wsc_ctl_model.xfer(1'b1, 13'h1FAA);
      wait_load(seen, 40);
    join
    chk("upper strobe load", 32'h0, {31'h0, seen});
    fork
      i_wsc_ctl_model.xfer(1'b0, 13'h1555);
      wait_load(seen, 40);
    join
    chk("full index", {13'h0, 6'h2A, 13'h1555}, {13'h0, seq_idx});
    fork
      i_wsc_ctl_model.send_full(19'h3_0ABC);
      wait_load(seen, 200);
    join
    chk("two-step index", 32'h0003_0ABC, {13'h0, seq_idx});
    fork
      i_wsc_ctl_model.xfer(1'b0, 13'h0123);
      wait_load(seen, 40);
    join
    chk("lower only index", {13'h0, 6'h18, 13'h0123}, {13'h0, seq_idx});
  endtask : t_port
  // Software index when selected
  task automatic t_swidx;
    logic seen;
    apb(1'b1, WSC_A_CTRL, 32'h0000_0200);
    fork
      apb(1'b1, WSC_A_SWIDX, 32'h0005_4321);
      wait_load(seen, 40);
    join
    chk("software index", 32'h0005_4321, {13'h0, seq_idx});
    apb(1'b1, WSC_A_CTRL, 32'h0);
  endtask : t_swidx
  // Triggered start, auto hold, soft trigger, stop, falling edge
  task automatic t_trig;
    apb(1'b1, WSC_A_CTRL, 32'h0000_0001);
    apb(1'b1, WSC_A_CMD, 32'h0000_0001);
    repeat (100) @(posedge pclk);
    #1;
    chk("offset before start", OFFS, {18'h0, smp});
    wait_stat("idle before trigger", RUNB, 1'b0, 0);
    i_wsc_ctl_model.set_trig(1'b1);
    wait_stat("trigger start", RUNB, 1'b1, 200);
    i_wsc_ctl_model.set_trig(1'b0);
    wait_stat("auto hold", HOLDB, 1'b1, 2000);
    apb(1'b1, WSC_A_CMD, 32'h0000_0004);
    wait_stat("soft trigger", HOLDB, 1'b0, 200);
    // External element end cuts the segment short
    @(posedge pclk);
    seg_end <= 1'b1;
    wait_stat("element cut", HOLDB, 1'b1, 150);
    @(posedge pclk);
    seg_end <= 1'b0;
    stop_run();
    repeat (3) @(posedge pclk);
    #1;
    wait_stat("stop halts", RUNB, 1'b0, 0);
    chk("offset after stop", OFFS, {18'h0, smp});
    apb(1'b1, WSC_A_CTRL, 32'h0000_0041);
    apb(1'b1, WSC_A_CMD, 32'h0000_0001);
    i_wsc_ctl_model.set_trig(1'b1);
    repeat (150) @(posedge pclk);
    wait_stat("rising ignored", RUNB, 1'b0, 0);
    i_wsc_ctl_model.set_trig(1'b0);
    wait_stat("falling starts", RUNB, 1'b1, 200);
    stop_run();
    // Armed: software trigger alone does not start
    apb(1'b1, WSC_A_CTRL, 32'h0000_0005);
    apb(1'b1, WSC_A_CMD, 32'h0000_0005);
    repeat (100) @(posedge pclk);
    wait_stat("armed needs enable", RUNB, 1'b0, 0);
    apb(1'b1, WSC_A_CMD, 32'h0000_0014);
    wait_stat("enable starts", RUNB, 1'b1, 200);
    stop_run();
  endtask : t_trig
  // Gated run, then free-running continuous
  task automatic t_gate;
    apb(1'b1, WSC_A_CTRL, 32'h0000_0002);
    apb(1'b1, WSC_A_CMD, 32'h0000_0001);
    i_wsc_ctl_model.set_trig(1'b1);
    wait_stat("gate start", RUNB, 1'b1, 200);
    repeat (1000) @(posedge pclk);
    wait_stat("gate loops", HOLDB, 1'b0, 0);
    i_wsc_ctl_model.set_trig(1'b0);
    wait_stat("gate finish hold", HOLDB, 1'b1, 2000);
    stop_run();
    apb(1'b1, WSC_A_CTRL, 32'h0);
    apb(1'b1, WSC_A_CMD, 32'h0000_0001);
    wait_stat("continuous start", RUNB, 1'b1, 200);
    repeat (2000) @(posedge pclk);
    wait_stat("continuous repeats", HOLDB, 1'b0, 0);
    stop_run();
  endtask : t_gate
  // Stored advancement events, pin and software
  task automatic t_event;
    apb(1'b1, WSC_A_CTRL, 32'h0000_0009);
    apb(1'b1, WSC_A_CMD, 32'h0000_0005);
    wait_stat("conditional start", RUNB, 1'b1, 200);
    i_wsc_ctl_model.set_event(1'b1);
    wait_stat("event stored", EVB, 1'b1, 200);
    i_wsc_ctl_model.set_event(1'b0);
    wait_stat("event consumed", EVB, 1'b0, 1000);
    apb(1'b1, WSC_A_CMD, 32'h0000_0020);
    wait_stat("soft event stored", EVB, 1'b1, 200);
    stop_run();
  endtask : t_event

  // Main sequence
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    seg_end = 1'b0;
    presetn = 1'b0;
    failures = 0;
    n_compared = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_port();
    t_swidx();
    t_trig();
    t_gate();
    t_event();
    close_out();
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    close_out();
  end
endmodule : tb
`default_nettype wire
